// ### hw/ads_regs.sv
// Data and status register bank of the three-axis accelerometer
// Operation
// R1 - Read-only identity byte at address zero holds a fixed part code.
// R2 - X sample: bits 3..0 in low byte top nibble, 11..4 in high.
// R3 - Y sample uses the same split across its two result bytes.
// R4 - Z sample same split; six result bytes read-only, reset zero.
// R5 - Motion status bit 0 shows significant motion event.
// R6 - Motion status bit 2 shows slope event; other bits read zero.
// R7 - FIFO status bit 5 shows FIFO full event.
// R8 - FIFO status bit 6 shows FIFO watermark event.
// R9 - FIFO status bit 7 shows new sample; bits 4..0 read zero.
// R10 - Mode config: 3-bit mode top, reserved bit, interval, data select.
// R11 - Writing either FIFO config clears full, watermark, and empties FIFO.
// R12 - Axis results are two's complement twelve-bit values.
// R13 - Writes to read-only, reserved bits or addresses have no effect.
`timescale 1ns/1ps
`include "ads_params.svh"
module ads_regs
   import ads_pkg::*;
#(
   parameter ads_byte_t PART_ID = `ADS_PART_ID_DEFAULT
)
(
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire ads_byte_t i_addr,
   input wire ads_byte_t i_wdata,
   input wire logic i_sample_valid,
   input wire ads_sample_t i_x_accel_sample,
   input wire ads_sample_t i_y_accel_sample,
   input wire ads_sample_t i_z_accel_sample,
   input wire logic i_significant_motion_flag,
   input wire logic i_slope_motion_flag,
   input wire logic i_fifo_full_flag,
   input wire logic i_fifo_watermark_flag,
   input wire logic i_new_sample_flag,
   input wire ads_byte_t i_fifo_read_byte,
   output ads_byte_t o_rdata,
   output logic o_fifo_read_pulse,
   output logic o_fifo_clear,
   output ads_byte_t o_x_offset_value,
   output ads_byte_t o_y_offset_value,
   output ads_byte_t o_z_offset_value,
   output logic [6:0] o_fifo_watermark_level,
   output logic [2:0] o_fifo_mode,
   output logic [1:0] o_select_a,
   output logic [1:0] o_fifo_data_select
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      ads_sample_t x;
      ads_sample_t y;
      ads_sample_t z;
      logic sig_mot;
      logic slope;
      logic ffull;
      logic fwm;
      logic newdat;
      ads_byte_t ofs_x;
      ads_byte_t ofs_y;
      ads_byte_t ofs_z;
      ads_byte_t wm_cfg;
      ads_byte_t mode_cfg;
      ads_byte_t rdata;
      logic fifo_rd;
      logic fifo_clr;
   } ads_state_t;

   ads_state_t state_r;
   ads_state_t state_nxt;
   ads_byte_t x_lo;
   ads_byte_t x_hi;
   ads_byte_t y_lo;
   ads_byte_t y_hi;
   ads_byte_t z_lo;
   ads_byte_t z_hi;
   logic cfg_wr;

   // ----------------------------------------
   // Result byte formatting
   // ----------------------------------------
   // Two's complement samples pass through unaltered
   ads_sample_split u_split_x ( // R2 R12
      .i_sample(state_r.x),
      .o_low(x_lo),
      .o_high(x_hi)
   );
   ads_sample_split u_split_y ( // R3
      .i_sample(state_r.y),
      .o_low(y_lo),
      .o_high(y_hi)
   );
   ads_sample_split u_split_z ( // R4
      .i_sample(state_r.z),
      .o_low(z_lo),
      .o_high(z_hi)
   );

   // Either FIFO config write counts as a FIFO clear
   assign cfg_wr = i_wr && (i_addr == `ADS_OFS_FIFO_WM_CFG ||
      i_addr == `ADS_OFS_FIFO_MODE_CFG); // R11

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      state_nxt = state_r;
      state_nxt.fifo_rd = 1'b0;
      state_nxt.fifo_clr = cfg_wr; // R11
      // Capture a fresh sample set
      if (i_sample_valid) begin
         state_nxt.x = i_x_accel_sample;
         state_nxt.y = i_y_accel_sample;
         state_nxt.z = i_z_accel_sample;
      end
      // Status follows the event sources
      state_nxt.sig_mot = i_significant_motion_flag; // R5
      state_nxt.slope = i_slope_motion_flag; // R6
      state_nxt.newdat = i_new_sample_flag; // R9
      // FIFO events: a new event beats the config clear
      state_nxt.ffull = i_fifo_full_flag || (state_r.ffull && !cfg_wr);
      state_nxt.fwm = i_fifo_watermark_flag || (state_r.fwm && !cfg_wr);
      if (cfg_wr) begin
         state_nxt.ffull = i_fifo_full_flag; // R7 R11
         state_nxt.fwm = i_fifo_watermark_flag; // R8 R11
      end
      // Writable registers; others ignore writes
      if (i_wr) begin
         unique case (i_addr)
            `ADS_OFS_X_OFFSET: state_nxt.ofs_x = i_wdata;
            `ADS_OFS_Y_OFFSET: state_nxt.ofs_y = i_wdata;
            `ADS_OFS_Z_OFFSET: state_nxt.ofs_z = i_wdata;
            `ADS_OFS_FIFO_WM_CFG: begin
               state_nxt.wm_cfg = i_wdata & `ADS_WM_LEVEL_MASK; // R13
            end
            `ADS_OFS_FIFO_MODE_CFG: begin
               state_nxt.mode_cfg = i_wdata & `ADS_MODE_CFG_MASK; // R10
            end
            default: state_nxt.rdata = state_r.rdata; // R13
         endcase
      end
      // Read data mux; unmapped reads zero
      if (i_rd) begin
         unique case (i_addr)
            `ADS_OFS_PART_ID: state_nxt.rdata = PART_ID; // R1
            `ADS_OFS_X_LOW: state_nxt.rdata = x_lo; // R2
            `ADS_OFS_X_HIGH: state_nxt.rdata = x_hi; // R2
            `ADS_OFS_Y_LOW: state_nxt.rdata = y_lo; // R3
            `ADS_OFS_Y_HIGH: state_nxt.rdata = y_hi; // R3
            `ADS_OFS_Z_LOW: state_nxt.rdata = z_lo; // R4
            `ADS_OFS_Z_HIGH: state_nxt.rdata = z_hi; // R4
            `ADS_OFS_MOTION_STS: begin
               state_nxt.rdata = `ADS_RESET_BYTE;
               state_nxt.rdata[`ADS_BIT_SIG_MOT] = state_r.sig_mot; // R5
               state_nxt.rdata[`ADS_BIT_SLOPE] = state_r.slope; // R6
            end
            `ADS_OFS_FIFO_STS: begin
               state_nxt.rdata = `ADS_RESET_BYTE;
               state_nxt.rdata[`ADS_BIT_FIFO_FULL] = state_r.ffull; // R7
               state_nxt.rdata[`ADS_BIT_FIFO_WM] = state_r.fwm; // R8
               state_nxt.rdata[`ADS_BIT_NEW_DATA] = state_r.newdat; // R9
            end
            `ADS_OFS_X_OFFSET: state_nxt.rdata = state_r.ofs_x;
            `ADS_OFS_Y_OFFSET: state_nxt.rdata = state_r.ofs_y;
            `ADS_OFS_Z_OFFSET: state_nxt.rdata = state_r.ofs_z;
            `ADS_OFS_FIFO_WM_CFG: state_nxt.rdata = state_r.wm_cfg;
            `ADS_OFS_FIFO_MODE_CFG: state_nxt.rdata = state_r.mode_cfg;
            `ADS_OFS_FIFO_READ: begin
               state_nxt.rdata = i_fifo_read_byte;
               state_nxt.fifo_rd = 1'b1;
            end
            default: state_nxt.rdata = `ADS_RESET_BYTE; // R13
         endcase
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Outputs straight from flops
   assign o_rdata = state_r.rdata;
   assign o_fifo_read_pulse = state_r.fifo_rd;
   assign o_fifo_clear = state_r.fifo_clr;
   assign o_x_offset_value = state_r.ofs_x;
   assign o_y_offset_value = state_r.ofs_y;
   assign o_z_offset_value = state_r.ofs_z;
   assign o_fifo_watermark_level = state_r.wm_cfg[6:0];
   assign o_fifo_mode = state_r.mode_cfg[7:5];
   assign o_select_a = state_r.mode_cfg[3:2];
   assign o_fifo_data_select = state_r.mode_cfg[1:0];

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_id_read;
      @(posedge i_clock) disable iff (i_reset)
      i_rd && i_addr == `ADS_OFS_PART_ID |=> o_rdata == PART_ID;
   endproperty
   a_id_read: assert property (p_id_read) // R1
      else $error("identity read wrong");

   property p_x_low;
      @(posedge i_clock) disable iff (i_reset)
      i_rd && i_addr == `ADS_OFS_X_LOW |=>
         o_rdata == {$past(state_r.x[3:0]), 4'h0};
   endproperty
   a_x_low: assert property (p_x_low) // R2
      else $error("x low byte wrong");

   property p_y_high;
      @(posedge i_clock) disable iff (i_reset)
      i_rd && i_addr == `ADS_OFS_Y_HIGH |=>
         o_rdata == $past(state_r.y[11:4]);
   endproperty
   a_y_high: assert property (p_y_high) // R3
      else $error("y high byte wrong");

   property p_z_low;
      @(posedge i_clock) disable iff (i_reset)
      i_rd && i_addr == `ADS_OFS_Z_LOW |=> o_rdata[3:0] == 4'h0;
   endproperty
   a_z_low: assert property (p_z_low) // R4
      else $error("z low reserved nibble set");

   property p_motion;
      @(posedge i_clock) disable iff (i_reset)
      i_rd && i_addr == `ADS_OFS_MOTION_STS |=>
         o_rdata == {5'h00, $past(state_r.slope), 1'b0,
         $past(state_r.sig_mot)};
   endproperty
   a_motion: assert property (p_motion) // R5 R6
      else $error("motion status wrong");

   property p_full_set;
      @(posedge i_clock) disable iff (i_reset)
      i_fifo_full_flag |=> state_r.ffull;
   endproperty
   a_full_set: assert property (p_full_set) // R7
      else $error("fifo full lost");

   property p_wm_clear;
      @(posedge i_clock) disable iff (i_reset)
      cfg_wr && !i_fifo_watermark_flag |=> !state_r.fwm ##0 o_fifo_clear;
   endproperty
   a_wm_clear: assert property (p_wm_clear) // R8 R11
      else $error("watermark not cleared");

   property p_fifo_sts;
      @(posedge i_clock) disable iff (i_reset)
      i_rd && i_addr == `ADS_OFS_FIFO_STS |=> o_rdata[4:0] == 5'h00;
   endproperty
   a_fifo_sts: assert property (p_fifo_sts) // R9
      else $error("fifo status reserved bits set");

   property p_mode_rsvd;
      @(posedge i_clock) disable iff (i_reset)
      1'b1 |-> state_r.mode_cfg[4] == 1'b0;
   endproperty
   a_mode_rsvd: assert property (p_mode_rsvd) // R10
      else $error("mode reserved bit set");

   property p_ro_write;
      @(posedge i_clock) disable iff (i_reset)
      i_wr && i_addr == `ADS_OFS_RSVD_GAP |=> $stable(state_r.ofs_x) &&
         $stable(state_r.ofs_y) && $stable(state_r.ofs_z) &&
         $stable(state_r.wm_cfg) && $stable(state_r.mode_cfg);
   endproperty
   a_ro_write: assert property (p_ro_write) // R13
      else $error("reserved write had effect");

   property p_clear_pulse;
      @(posedge i_clock) disable iff (i_reset)
      cfg_wr |=> o_fifo_clear;
   endproperty
   a_clear_pulse: assert property (p_clear_pulse) // R11
      else $error("fifo clear pulse missing");

   property p_full_clear;
      @(posedge i_clock) disable iff (i_reset)
      cfg_wr && !i_fifo_full_flag |=> !state_r.ffull;
   endproperty
   a_full_clear: assert property (p_full_clear) // R7 R11
      else $error("fifo full not cleared");

   property p_wm_set;
      @(posedge i_clock) disable iff (i_reset)
      i_fifo_watermark_flag |=> state_r.fwm;
   endproperty
   a_wm_set: assert property (p_wm_set) // R8
      else $error("watermark event lost");

   property p_mode_write;
      @(posedge i_clock) disable iff (i_reset)
      i_wr && i_addr == `ADS_OFS_FIFO_MODE_CFG |=>
         o_fifo_mode == $past(i_wdata[7:5]) &&
         o_select_a == $past(i_wdata[3:2]) &&
         o_fifo_data_select == $past(i_wdata[1:0]);
   endproperty
   a_mode_write: assert property (p_mode_write) // R10
      else $error("mode fields not stored");
endmodule

// ### include/ads_params.svh
// Register map, field positions and reset values of the data/status bank
`ifndef ADS_PARAMS_SVH
`define ADS_PARAMS_SVH

`define ADS_ADDR_W 8
`define ADS_DATA_W 8
`define ADS_OFS_PART_ID 8'h00
`define ADS_OFS_X_LOW 8'h02
`define ADS_OFS_X_HIGH 8'h03
`define ADS_OFS_Y_LOW 8'h04
`define ADS_OFS_Y_HIGH 8'h05
`define ADS_OFS_Z_LOW 8'h06
`define ADS_OFS_Z_HIGH 8'h07
`define ADS_OFS_MOTION_STS 8'h09
`define ADS_OFS_FIFO_STS 8'h0a
`define ADS_OFS_RSVD_GAP 8'h37
`define ADS_OFS_X_OFFSET 8'h38
`define ADS_OFS_Y_OFFSET 8'h39
`define ADS_OFS_Z_OFFSET 8'h3a
`define ADS_OFS_FIFO_WM_CFG 8'h3d
`define ADS_OFS_FIFO_MODE_CFG 8'h3e
`define ADS_OFS_FIFO_READ 8'h3f
// Status bit positions
`define ADS_BIT_SIG_MOT 0
`define ADS_BIT_SLOPE 2
`define ADS_BIT_FIFO_FULL 5
`define ADS_BIT_FIFO_WM 6
`define ADS_BIT_NEW_DATA 7
// Low register: sample bits 3..0 sit in bits 7..4
`define ADS_LOW_NIB_LSB 4
`define ADS_SAMPLE_W 12
// Mode config fields
`define ADS_MODE_LSB 5
`define ADS_INTERVAL_LSB 2
`define ADS_DSEL_LSB 0
`define ADS_WM_LEVEL_MASK 8'h7f
`define ADS_MODE_CFG_MASK 8'hef
`define ADS_RESET_BYTE 8'h00
// Identity code: arbitrary neutral value
`define ADS_PART_ID_DEFAULT 8'h5a

`endif

// ### include/ads_pkg.sv
// Types shared by the accelerometer data/status bank
package ads_pkg;
   typedef logic [7:0] ads_byte_t;
   typedef logic [11:0] ads_sample_t;
endpackage

// ### hw/ads_sample_split.sv
// Splits one 12-bit axis sample into its low and high result bytes
`timescale 1ns/1ps
`include "ads_params.svh"
module ads_sample_split
   import ads_pkg::*;
(
   input wire ads_sample_t i_sample,
   output ads_byte_t o_low,
   output ads_byte_t o_high
);
   // Low nibble to upper half, reserved half zero; rest to high byte
   assign o_low = {i_sample[3:0], 4'h0};
   assign o_high = i_sample[11:4];
endmodule

// ### test/ads_core_model.sv
// Sensing-core stand-in that hands axis samples to the bank
`timescale 1ns/1ps
module ads_core_model
   import ads_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_load,
   input wire ads_sample_t i_x,
   input wire ads_sample_t i_y,
   input wire ads_sample_t i_z,
   output logic o_valid,
   output ads_sample_t o_x,
   output ads_sample_t o_y,
   output ads_sample_t o_z
);
   ads_sample_t x_r, y_r, z_r;
   // Capture a sample set, offer it for one cycle
   always_ff @(posedge i_clock) begin
      o_valid <= i_load & ~i_reset;
      if (i_load) begin
         x_r <= i_x;
         y_r <= i_y;
         z_r <= i_z;
      end
   end
   // Outside the valid cycle the lines carry junk
   assign o_x = o_valid ? x_r : ~x_r;
   assign o_y = o_valid ? y_r : ~y_r;
   assign o_z = o_valid ? z_r : ~z_r;
endmodule

// ### test/tb.sv
// Self-checking bench for the data/status register bank
`timescale 1ns/1ps
`include "ads_params.svh"
module tb;
   import ads_pkg::*;
   logic i_clock = 1'b0;
   logic i_reset = 1'b1;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic ld = 1'b0;
   logic mv, rp, clr;
   logic sig = 1'b0, slp = 1'b0, ful = 1'b0, wmk = 1'b0, nsf = 1'b0;
   logic full_e = 1'b0, wms_e = 1'b0;
   ads_byte_t i_addr = 8'h00, i_wdata = 8'h00, fb = 8'h00;
   ads_byte_t o_rdata, xo, yo, zo;
   ads_byte_t ox = 8'h00, oy = 8'h00, oz = 8'h00;
   ads_byte_t wm_e = 8'h00, md_e = 8'h00;
   ads_sample_t sx = 12'h000, sy = 12'h000, sz = 12'h000, mx, my, mz;
   logic [6:0] wl;
   logic [2:0] md;
   logic [1:0] sa, ds;
   int bad_count = 0;
   int check_count = 0;

   // Clock
   always #2 i_clock = ~i_clock;

   ads_core_model core (.i_clock(i_clock), .i_reset(i_reset),
      .i_load(ld), .i_x(sx), .i_y(sy), .i_z(sz), .o_valid(mv),
      .o_x(mx), .o_y(my), .o_z(mz));

   ads_regs uut (.i_clock(i_clock), .i_reset(i_reset), .i_wr(i_wr),
      .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_sample_valid(mv), .i_x_accel_sample(mx),
      .i_y_accel_sample(my), .i_z_accel_sample(mz),
      .i_significant_motion_flag(sig), .i_slope_motion_flag(slp),
      .i_fifo_full_flag(ful), .i_fifo_watermark_flag(wmk),
      .i_new_sample_flag(nsf), .i_fifo_read_byte(fb),
      .o_rdata(o_rdata), .o_fifo_read_pulse(rp), .o_fifo_clear(clr),
      .o_x_offset_value(xo), .o_y_offset_value(yo),
      .o_z_offset_value(zo), .o_fifo_watermark_level(wl),
      .o_fifo_mode(md), .o_select_a(sa), .o_fifo_data_select(ds));

   // -----------------------------
   // Expected register contents
   // -----------------------------
   function automatic ads_byte_t exp_reg(input ads_byte_t a);
      case (a)
         8'h00: return `ADS_PART_ID_DEFAULT;
         8'h02: return {sx[3:0], 4'h0};
         8'h03: return sx[11:4];
         8'h04: return {sy[3:0], 4'h0};
         8'h05: return sy[11:4];
         8'h06: return {sz[3:0], 4'h0};
         8'h07: return sz[11:4];
         8'h09: return {5'h00, slp, 1'b0, sig};
         8'h0a: return {nsf, wms_e, full_e, 5'h00};
         8'h38: return ox;
         8'h39: return oy;
         8'h3a: return oz;
         8'h3d: return wm_e;
         8'h3e: return md_e;
         8'h3f: return fb;
         default: return 8'h00;
      endcase
   endfunction

   // -----------------------------
   // Access tasks
   // -----------------------------
   task automatic check(input string n, input ads_byte_t s,
      input ads_byte_t e);
      check_count++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic rd(input ads_byte_t a, input ads_byte_t e);
      @(posedge i_clock);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1;
      check($sformatf("reg %h", a), o_rdata, e);
      check("read_pulse", {7'h00, rp}, {7'h00, a == 8'h3f});
   endtask

   task automatic wr(input ads_byte_t a, input ads_byte_t d);
      @(posedge i_clock);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr <= 1'b0;
      #1;
      check("clear", {7'h00, clr}, {7'h00, a == 8'h3d || a == 8'h3e});
   endtask

   task automatic sweep();
      for (int a = 0; a < 64; a++) begin
         rd(8'(a), exp_reg(8'(a)));
      end
   endtask

   task automatic load(input ads_sample_t x, y, z);
      int n;
      @(posedge i_clock);
      sx <= x;
      sy <= y;
      sz <= z;
      ld <= 1'b1;
      @(posedge i_clock);
      ld <= 1'b0;
      #1;
      for (n = 0; n < 8 && mv !== 1'b1; n++) @(posedge i_clock);
      if (mv !== 1'b1) begin
         bad_count++;
         close_out();
      end
   endtask

   task automatic pulse_fifo_flags();
      @(posedge i_clock);
      ful <= 1'b1;
      wmk <= 1'b1;
      @(posedge i_clock);
      ful <= 1'b0;
      wmk <= 1'b0;
      full_e = 1'b1;
      wms_e = 1'b1;
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // -----------------------------
   // Main sequence
   // -----------------------------
   initial begin
      repeat (12) @(posedge i_clock);
      i_reset <= 1'b0;
      sweep();
      $display("test reset values done");
      @(posedge i_clock);
      sig <= 1'b1;
      slp <= 1'b1;
      nsf <= 1'b1;
      fb <= 8'h3c;
      load(12'h800, 12'h7ff, 12'ha5c);
      sweep();
      @(posedge i_clock);
      sig <= 1'b0;
      nsf <= 1'b0;
      rd(8'h09, 8'h04);
      rd(8'h0a, 8'h00);
      $display("test samples and live flags done");
      pulse_fifo_flags();
      rd(8'h0a, 8'h60);
      wr(8'h3d, 8'hff);
      full_e = 1'b0;
      wms_e = 1'b0;
      wm_e = 8'h7f;
      check("wm_level", {1'b0, wl}, 8'h7f);
      rd(8'h0a, 8'h00);
      rd(8'h3d, 8'h7f);
      pulse_fifo_flags();
      // Full event stands while the config write lands
      @(posedge i_clock);
      ful <= 1'b1;
      wr(8'h3e, 8'hff);
      check("mode", {5'h00, md}, 8'h07);
      check("interval", {6'h00, sa}, 8'h03);
      check("data_sel", {6'h00, ds}, 8'h03);
      @(posedge i_clock);
      ful <= 1'b0;
      wms_e = 1'b0;
      md_e = 8'hef;
      rd(8'h0a, 8'h20);
      rd(8'h3e, 8'hef);
      $display("test fifo config done");
      wr(8'h38, 8'h81);
      wr(8'h39, 8'h7e);
      wr(8'h3a, 8'hc3);
      ox = 8'h81;
      oy = 8'h7e;
      oz = 8'hc3;
      check("x_offset", xo, 8'h81);
      check("y_offset", yo, 8'h7e);
      check("z_offset", zo, 8'hc3);
      wr(8'h00, 8'hff);
      wr(8'h03, 8'hff);
      wr(8'h09, 8'hff);
      wr(8'h0a, 8'hff);
      wr(8'h37, 8'hff);
      wr(8'h3f, 8'hff);
      sweep();
      $display("test writes and read-only places done");
      // Mid-run reset brings every register except the identity byte back to zero
      @(posedge i_clock);
      i_reset <= 1'b1;
      slp <= 1'b0;
      fb <= 8'h00;
      sx <= 12'h000;
      sy <= 12'h000;
      sz <= 12'h000;
      repeat (3) @(posedge i_clock);
      i_reset <= 1'b0;
      full_e = 1'b0;
      ox = 8'h00;
      oy = 8'h00;
      oz = 8'h00;
      wm_e = 8'h00;
      md_e = 8'h00;
      sweep();
      check("x_offset", xo, 8'h00);
      check("wm_level", {1'b0, wl}, 8'h00);
      check("mode", {5'h00, md}, 8'h00);
      $display("test mid-run reset done");
      close_out();
   end
endmodule
